// ---- verilog/burst_sram_params.svh ----
// Purpose: constants of the flow-through burst sram model
// Assumes: one 40 MHz clock
// Notes: none
`ifndef BURST_SRAM_PARAMS_SVH
`define BURST_SRAM_PARAMS_SVH
`define ADDR_BITS      19
`define LANES          4
`define LANE_BITS      9
`define BURST_LSBS     2
`define SLEEP_CYCLES   2
`define CLOCK_PERIOD_PS 25000
`define DATA_VALID_PS  6500
`define ORDER_LINEAR   1'h0
`endif

// ---- verilog/burst_sram_pkg.sv ----
// Purpose: types of the flow-through burst sram model
// Assumes: nothing
// Notes: none
package burst_sram_pkg;
   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_read  = 4'h2,
      st_write = 4'h4,
      st_sleep = 4'h8
   } sram_state_t;
endpackage

// ---- verilog/flowthrough_burst_sram.sv ----
// Purpose: flow-through burst sram with zero turnaround between accesses
// Assumes: host inputs synchronous to clock; oe, sleep pins level inputs
// Notes: data pins are split into in, out and output enable
`timescale 1ns/1ps
`include "burst_sram_params.svh"

module flowthrough_burst_sram #(
   parameter int ADDR_W = `ADDR_BITS,
   parameter int LANES  = `LANES
) (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rstn,
   // control
   input  wire logic                     clock_qualify_n,
   input  wire logic                     chip_select_a_n,
   input  wire logic                     chip_select_b,
   input  wire logic                     chip_select_c_n,
   input  wire logic                     advance_or_load,
   input  wire logic                     write_n,
   input  wire logic [LANES-1:0]         byte_lane_write_n,
   input  wire logic                     output_enable_n,
   input  wire logic                     burst_order,
   input  wire logic                     sleep_request,
   input  wire logic [ADDR_W-1:0]        address,
   // data and parity
   input  wire logic [LANES*8-1:0]       data_in,
   input  wire logic [LANES-1:0]         parity_in,
   output logic      [LANES*8-1:0]       data_out,
   output logic      [LANES-1:0]         parity_out,
   output logic                          data_oe,
   // status
   output logic                          sleeping
);
   import burst_sram_pkg::*;

   localparam int LW = `LANE_BITS;
   localparam int WORDS = 1 << ADDR_W;
   localparam int SLP_W = 2;
   localparam logic [SLP_W-1:0] SLP_N = SLP_W'(`SLEEP_CYCLES);
   // least valid time is a maximum, so the count rounds down, never below one
   localparam int DV_CYC_RAW = `DATA_VALID_PS / `CLOCK_PERIOD_PS;
   localparam int DV_CYC = (DV_CYC_RAW < 1) ? 1 : DV_CYC_RAW;

   initial begin
      if (LANES != `LANES || ADDR_W < `BURST_LSBS || ADDR_W > 24)
         $error("unsupported sram geometry");
   end

   logic [LANES*LW-1:0] mem [WORDS];
   sram_state_t state_q;
   logic [ADDR_W-1:0] base_q;
   logic [1:0] count_q;
   logic [SLP_W-1:0] slp_cnt_q;

   wire active = ~clock_qualify_n;
   wire sel_all = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;

   function automatic logic [1:0] burst_lsbs(input logic [1:0] s, input logic [1:0] c,
                                              input logic order);
      if (order == `ORDER_LINEAR)
         burst_lsbs = s + c;
      else
         burst_lsbs = s ^ c;
   endfunction

   wire [1:0] cur_lsbs = burst_lsbs(base_q[1:0], count_q, burst_order);
   wire [ADDR_W-1:0] cur_addr = {base_q[ADDR_W-1:`BURST_LSBS], cur_lsbs};
   wire in_access = (state_q == st_read) || (state_q == st_write);

   // sleep: two clocks to enter, two to leave; qualifier does not gate it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         slp_cnt_q <= '0;
      end else if (sleep_request != (state_q == st_sleep)) begin
         slp_cnt_q <= (slp_cnt_q == SLP_N - 1'b1) ? '0 : slp_cnt_q + 1'b1;
      end else begin
         slp_cnt_q <= '0;
      end
   end
   wire slp_flip = (sleep_request != (state_q == st_sleep)) && (slp_cnt_q == SLP_N - 1'b1);

   // access sequencing
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= st_idle;
         base_q  <= '0;
         count_q <= '0;
      end else if (slp_flip) begin
         // pending access is abandoned; contents stay intact
         state_q <= sleep_request ? st_sleep : st_idle;
         count_q <= '0;
      end else if (state_q == st_sleep) begin
         state_q <= st_sleep;
      end else if (active) begin
         if (!advance_or_load) begin
            if (sel_all) begin
               base_q  <= address;
               count_q <= '0;
               state_q <= write_n ? st_read : st_write;
            end else begin
               state_q <= st_idle;
            end
         end else begin
            count_q <= count_q + 2'h1;
         end
      end
   end

   // write data taken at the edge after the address edge, per lane
   // one process owns the array so it has a single driver
   always_ff @(posedge clock) begin
      if (active && state_q == st_write && !slp_flip) begin
         for (int g = 0; g < LANES; g++) begin
            if (!byte_lane_write_n[g])
               mem[cur_addr][g*LW +: LW] <= {parity_in[g], data_in[g*8 +: 8]};
         end
      end
   end

   // output data for the current read beat
   always_comb begin
      data_out   = '0;
      parity_out = '0;
      for (int i = 0; i < LANES; i++) begin
         data_out[i*8 +: 8] = mem[cur_addr][i*LW +: 8];
         parity_out[i]      = mem[cur_addr][i*LW + 8];
      end
   end

   assign data_oe = (state_q == st_read) && !output_enable_n;
   assign sleeping = (state_q == st_sleep);

   property p_freeze;
      @(posedge clock) disable iff (!rstn)
      (clock_qualify_n && !slp_flip && state_q != st_sleep) |=> $stable(count_q) && $stable(state_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while stalled");

   property p_load;
      @(posedge clock) disable iff (!rstn)
      (active && !advance_or_load && sel_all && !slp_flip && state_q != st_sleep)
         |=> base_q == $past(address) && count_q == 2'h0;
   endproperty
   a_load: assert property (p_load) else $error("address not loaded");

   property p_deselect;
      @(posedge clock) disable iff (!rstn)
      (active && !advance_or_load && !sel_all && state_q != st_sleep) |=> !data_oe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("drivers on after deselect");

   property p_write_off;
      @(posedge clock) disable iff (!rstn)
      (state_q == st_write) |-> !data_oe;
   endproperty
   a_write_off: assert property (p_write_off) else $error("drivers on during write");

   property p_read_on;
      @(posedge clock) disable iff (!rstn)
      (active && !advance_or_load && sel_all && write_n && !slp_flip && state_q != st_sleep)
         ##1 !output_enable_n |-> data_oe;
   endproperty
   a_read_on: assert property (p_read_on) else $error("read data not driven");

   property p_advance;
      @(posedge clock) disable iff (!rstn)
      (active && advance_or_load && !slp_flip && state_q != st_sleep)
         |=> count_q == $past(count_q) + 2'h1 && state_q == $past(state_q);
   endproperty
   a_advance: assert property (p_advance) else $error("burst did not advance");

   property p_sleep_in;
      @(posedge clock) disable iff (!rstn)
      (state_q == st_idle && sleep_request)[*2] |=> sleeping;
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("sleep entry not two cycles");

   property p_wrap;
      @(posedge clock) disable iff (!rstn)
      (count_q == 2'h3 && active && advance_or_load && !slp_flip && state_q != st_sleep)
         |=> count_q == 2'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst counter did not wrap");

   c_read: cover property (@(posedge clock) disable iff (!rstn) state_q == st_read && data_oe);
   c_write: cover property (@(posedge clock) disable iff (!rstn) state_q == st_write);
   c_rw: cover property (@(posedge clock) disable iff (!rstn)
      state_q == st_write ##1 state_q == st_read);
   c_sleep: cover property (@(posedge clock) disable iff (!rstn) sleeping ##1 !sleeping);

endmodule // flowthrough_burst_sram

// ---- test/host_side_model.sv ----
// Purpose: host controller model driving the sram pins
// Assumes: pins change on the falling edge
// Notes: the wr task idles write data at its inverse so stale data never matches
`timescale 1ns/1ps
module host_side_model (
   // clock
   input  wire logic  clock,
   // control
   output logic       clock_qualify_n,
   output logic       chip_select_a_n,
   output logic       chip_select_b,
   output logic       chip_select_c_n,
   output logic       advance_or_load,
   output logic       write_n,
   output logic [3:0] byte_lane_write_n,
   output logic [18:0] address,
   // write data
   output logic [31:0] data_in,
   output logic [3:0] parity_in
);
   initial begin
      {clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n} = 4'h5;
      {advance_or_load, write_n, byte_lane_write_n} = 6'h1F;
      address = 19'h0;
      {parity_in, data_in} = 36'h0;
   end
   // callers reload after deselect except t_back_to_back, which advances; give lanes every beat, deselect around sleep
   // write data has its own input, so host never fights the drivers
   task automatic op(input logic q, input logic [2:0] cs, input logic ld, input logic wr,
                     input logic [3:0] be, input logic [18:0] a, input logic [35:0] d);
      @(negedge clock);
      clock_qualify_n = q;
      {chip_select_c_n, chip_select_b, chip_select_a_n} = cs ^ 3'h5;
      {advance_or_load, write_n, byte_lane_write_n} = {ld, wr, be};
      address = a;
      {parity_in, data_in} = d;
   endtask
endmodule // host_side_model

// ---- test/tb_flowthrough_burst_sram.sv ----
// Purpose: self-checking bench of the flow-through burst sram
// Assumes: inputs change on the falling edge
// Notes: sleep timing checked loosely, one spare cycle each way
`timescale 1ns/1ps
module tb_flowthrough_burst_sram;
   logic clock = 1'h0, rstn = 1'h0, output_enable_n = 1'h0;
   logic burst_order = 1'h0, sleep_request = 1'h0;
   logic clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n;
   logic advance_or_load, write_n, data_oe, sleeping;
   logic [3:0] byte_lane_write_n, parity_in, parity_out;
   logic [18:0] address;
   logic [31:0] data_in, data_out;
   logic [35:0] lanes_exp;
   int err_total = 0, compares = 0, cycles = 0;
   wire [35:0] word = {parity_out, data_out};
   always #12.5 clock = ~clock;
   host_side_model h (.clock, .clock_qualify_n, .chip_select_a_n, .chip_select_b,
      .chip_select_c_n, .advance_or_load, .write_n, .byte_lane_write_n, .address,
      .data_in, .parity_in);
   flowthrough_burst_sram dut (.clock, .rstn, .clock_qualify_n, .chip_select_a_n,
      .chip_select_b, .chip_select_c_n, .advance_or_load, .write_n, .byte_lane_write_n,
      .output_enable_n, .burst_order, .sleep_request, .address, .data_in, .parity_in,
      .data_out, .parity_out, .data_oe, .sleeping);
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] be);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (!be[i]) {merge[32+i], merge[8*i+:8]} = {n[32+i], n[8*i+:8]};
      end
   endfunction
   task automatic wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] be);
      h.op(1'h0, 3'h7, 1'h0, 1'h0, 4'hF, a, ~d);
      h.op(1'h0, 3'h0, 1'h0, 1'h1, be, a, d);
      chk("oe in write", 36'h0, {35'h0, data_oe});
   endtask
   task automatic rd(input logic [18:0] a, input logic [35:0] exp);
      h.op(1'h0, 3'h7, 1'h0, 1'h1, 4'hF, a, 36'h0);
      h.op(1'h0, 3'h0, 1'h0, 1'h1, 4'hF, a, 36'hF);
      chk("read word", exp, word);
      chk("oe in read", 36'h1, {35'h0, data_oe});
   endtask
   task automatic t_back_to_back();
      h.op(1'h0, 3'h7, 1'h0, 1'h0, 4'hF, 19'h10, 36'h0);
      h.op(1'h0, 3'h7, 1'h0, 1'h1, 4'h0, 19'h10, 36'h912345678);
      h.op(1'h0, 3'h7, 1'h1, 1'h0, 4'hF, 19'h10, 36'h0);
      chk("read after write", 36'h912345678, word);
      for (int i = 0; i < 3; i++) begin
         h.op(1'h0, 3'h7, 1'h0, 1'h1, 4'hF, 19'h10, 36'h0);
         h.op(1'h0, 3'h7 ^ (3'h1 << i), 1'h0, 1'h1, 4'hF, 19'h10, 36'h0);
         h.op(1'h0, 3'h7, 1'h1, 1'h1, 4'hF, 19'h10, 36'h0);
         chk("oe deselect", 36'h0, {35'h0, data_oe});
      end
      $display("test back_to_back done");
   endtask
   task automatic t_lanes();
      lanes_exp = merge(36'h0AABBCCDD, 36'hF11223344, 4'hA);
      wr(19'h20, 36'h0AABBCCDD, 4'h0);
      wr(19'h20, 36'hF11223344, 4'hA);
      rd(19'h20, lanes_exp);
      wr(19'h20, 36'h5A5A5A5A5, 4'hF);
      rd(19'h20, lanes_exp);
      $display("test lanes done");
   endtask
   task automatic t_burst();
      logic [1:0] lb;
      for (int j = 0; j < 4; j++) wr(19'h100 + j, 36'h300000000 + j, 4'h0);
      for (int o = 0; o < 2; o++) begin
         burst_order = o[0];
         h.op(1'h0, 3'h7, 1'h0, 1'h1, 4'hF, 19'h101, 36'h0);
         // beat index b repeats once after the qualifier-high edge; wr low is ignored
         for (int k = 0; k < 5; k++) begin
            h.op(k == 1, 3'h0, 1'h1, 1'h0, 4'h0, 19'h0, 36'h0);
            lb = 2'((k > 1) ? k - 1 : k);
            lb = o ? (2'h1 ^ lb) : (2'h1 + lb);
            chk("burst beat", 36'h300000000 + lb, word);
         end
         h.op(1'h0, 3'h0, 1'h0, 1'h1, 4'hF, 19'h0, 36'h0);
      end
      $display("test burst done");
   endtask
   task automatic t_sleep();
      h.op(1'h0, 3'h0, 1'h0, 1'h1, 4'hF, 19'h0, 36'h0);
      sleep_request = 1'h1;
      repeat (3) @(negedge clock);
      chk("sleeping", 36'h1, {35'h0, sleeping});
      sleep_request = 1'h0;
      repeat (3) @(negedge clock);
      chk("awake", 36'h0, {35'h0, sleeping});
      rd(19'h20, lanes_exp);
      $display("test sleep done");
   endtask
   initial begin
      repeat (2) @(negedge clock);
      chk("oe at reset", 36'h0, {35'h0, data_oe});
      rstn = 1'h1;
      t_back_to_back();
      t_lanes();
      t_burst();
      t_sleep();
      report_and_stop();
   end
endmodule // tb_flowthrough_burst_sram
